/* ioct_defines.svh */
/*
  constants for the i/o chain channel transmitter: selector address,
  broadcast code, status byte layout and fixed widths.
  assumes the includer compiles it once per unit; guarded anyway.
*/
`ifndef IOCT_DEFINES_SVH
`define IOCT_DEFINES_SVH

`define IOCT_SEL_ADDR 7'h7f
`define IOCT_BCAST_CODE 8'h80
`define IOCT_CHAN_W 3
`define IOCT_ADDR_W 7
`define IOCT_ST_CHAN_LSB 0
`define IOCT_ST_PRESENT_BIT 3
`define IOCT_ST_TRAP_BIT 6
`define IOCT_ST_FAULT_BIT 7
`define IOCT_STATUS_RST 8'h00

`endif

/* ioct_pkg.sv */
/*
  types shared by the transmitter modules.
  assumes ioct_defines.svh is on the include path.
*/
package ioct_pkg;
  typedef logic [7:0] ioct_byte_t;
  typedef logic [2:0] ioct_chan_t;
  typedef enum logic [1:0] {
    IOCT_DETACHED = 2'b00,
    IOCT_ATTACHED = 2'b01,
    IOCT_BCAST = 2'b10
  } ioct_link_t;
endpackage

/* ioct_sync.sv */
/*
  two-flop synchroniser for one level from a pin.
  assumes the level changes slowly relative to ref_clk.
*/
module ioct_sync (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic asyncIn,
  output logic syncOut
);
  typedef struct packed {
    logic stage1;
    logic stage2;
  } ioct_sync_t;
  ioct_sync_t st_reg;
  ioct_sync_t st_next;

  always_comb begin
    st_next.stage1 = asyncIn;
    st_next.stage2 = st_reg.stage1;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign syncOut = st_reg.stage2;
endmodule

/* ioct_status_fmt.sv */
/*
  assembles the status byte returned to the controller.
  assumes inputs already registered on ref_clk; purely combinational.
*/
module ioct_status_fmt
  import ioct_pkg::*;
(
  input wire ioct_pkg::ioct_chan_t chanNum,
  input wire logic cardPresent,
  input wire logic faultTrapEn,
  input wire logic faultPresent,
  output ioct_pkg::ioct_byte_t statusByte
);
  `include "ioct_defines.svh"
  always_comb begin
    statusByte = `IOCT_STATUS_RST;
    // bit 0 of the table lands on the lowest input
    statusByte[`IOCT_ST_CHAN_LSB +: `IOCT_CHAN_W] = chanNum;
    statusByte[`IOCT_ST_PRESENT_BIT] = cardPresent;
    statusByte[`IOCT_ST_TRAP_BIT] = faultTrapEn;
    statusByte[`IOCT_ST_FAULT_BIT] = faultPresent;
  end
endmodule

/* ioct_transmitter.sv */
/*
  i/o chain channel transmitter: watches controller output writes to
  the channel selector address, attaches or detaches its channel,
  answers reads of that address with a status byte, drives leds.
  assumes backplane strobes are on ref_clk; jumpers, switches and
  downstream/supply monitors are pins and are synchronised here.
*/
`include "ioct_defines.svh"

// Overview of operation
// - selector write equal to switch channel attaches this channel
// - selector write of any other value but 80h detaches this channel
// - broadcast 80h attaches every module but suppresses its input answer
// - status byte: channel, present, zeros, trap enable, fault present
// - mode jumper picks normal single chain or expanded selectable channel
// - fault-stop jumper picks system stop; led lit while enabled
// - channel number comes from first three switch segments
// - bad isolated supply shuts module down; power led shows good
// - chain-good led: station power good and continuity downstream
// - chain-parity led: output parity good at all downstream stations
module ioct_transmitter
  import ioct_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [6:0] ioAddr,
  input wire ioct_pkg::ioct_byte_t ioWrData,
  input wire logic ioWrStb,
  input wire logic ioRdStb,
  output ioct_pkg::ioct_byte_t ioRdData,
  output logic ioRdValid,
  input wire ioct_pkg::ioct_chan_t chanSwitch,
  input wire logic fault_stop_select_jumper,
  input wire logic chain_mode_select_jumper,
  input wire logic isoSupplyOk,
  input wire logic stationPowerOk,
  input wire logic cableContinuityOk,
  input wire logic downstreamParityOk,
  input wire logic localFault,
  output logic chainEnable,
  output logic systemStop,
  output logic ledChainOk,
  output logic ledChainParity,
  output logic ledIsoPower,
  output logic ledFaultEnable,
  output logic ledChainActive
);
  import ioct_pkg::*;

  typedef struct packed {
    ioct_link_t link;
    ioct_byte_t rdData;
    logic rdValid;
    logic chainEn;
    logic sysStop;
    logic ledOk;
    logic ledPar;
    logic ledIso;
    logic ledFault;
    logic ledActive;
  } ioct_state_t;

  ioct_state_t st_reg;
  ioct_state_t st_next;

  logic [2:0] chanSync;
  logic faultStopSync;
  logic expandedSync;
  logic isoOkSync;
  logic stnPwrSync;
  logic contSync;
  logic parSync;
  logic faultSync;
  ioct_byte_t statusByte;

  function automatic logic selHit(input logic [6:0] a);
    selHit = (a == `IOCT_SEL_ADDR);
  endfunction

  // all pin-level inputs through two flops before any logic
  ioct_sync u_sync_c0 (.ref_clk(ref_clk), .rst(rst), .asyncIn(chanSwitch[0]),
    .syncOut(chanSync[0]));
  ioct_sync u_sync_c1 (.ref_clk(ref_clk), .rst(rst), .asyncIn(chanSwitch[1]),
    .syncOut(chanSync[1]));
  ioct_sync u_sync_c2 (.ref_clk(ref_clk), .rst(rst), .asyncIn(chanSwitch[2]),
    .syncOut(chanSync[2]));
  ioct_sync u_sync_fs (.ref_clk(ref_clk), .rst(rst), .asyncIn(fault_stop_select_jumper),
    .syncOut(faultStopSync));
  ioct_sync u_sync_md (.ref_clk(ref_clk), .rst(rst), .asyncIn(chain_mode_select_jumper),
    .syncOut(expandedSync));
  ioct_sync u_sync_iso (.ref_clk(ref_clk), .rst(rst), .asyncIn(isoSupplyOk),
    .syncOut(isoOkSync));
  ioct_sync u_sync_pw (.ref_clk(ref_clk), .rst(rst), .asyncIn(stationPowerOk),
    .syncOut(stnPwrSync));
  ioct_sync u_sync_ct (.ref_clk(ref_clk), .rst(rst), .asyncIn(cableContinuityOk),
    .syncOut(contSync));
  ioct_sync u_sync_pa (.ref_clk(ref_clk), .rst(rst), .asyncIn(downstreamParityOk),
    .syncOut(parSync));
  ioct_sync u_sync_lf (.ref_clk(ref_clk), .rst(rst), .asyncIn(localFault),
    .syncOut(faultSync));

  ioct_status_fmt u_fmt (
    .chanNum(chanSync),
    .cardPresent(1'b1),
    .faultTrapEn(faultStopSync),
    .faultPresent(faultSync),
    .statusByte(statusByte)
  );

  always_comb begin
    st_next = st_reg;
    st_next.rdValid = 1'b0;
    st_next.rdData = `IOCT_STATUS_RST;
    if (!isoOkSync) begin
      // supply out of tolerance: drop everything off the chain
      st_next.link = IOCT_DETACHED;
    end else if (ioWrStb && selHit(ioAddr)) begin
      if (ioWrData == `IOCT_BCAST_CODE) begin
        st_next.link = IOCT_BCAST;
      end else if (ioWrData == {5'h00, chanSync}) begin
        st_next.link = IOCT_ATTACHED;
      end else begin
        st_next.link = IOCT_DETACHED;
      end
    end
    // only a selected, powered module answers; silence lets the
    // controller leave its table untouched
    if (ioRdStb && selHit(ioAddr) && isoOkSync && st_reg.link == IOCT_ATTACHED) begin
      st_next.rdValid = 1'b1;
      st_next.rdData = statusByte;
    end
    // normal mode: single non-selectable chain, attached while the isolated supply is good
    st_next.chainEn = isoOkSync && (!expandedSync || st_next.link != IOCT_DETACHED);
    st_next.sysStop = faultStopSync && faultSync;
    st_next.ledFault = faultStopSync;
    st_next.ledIso = isoOkSync;
    st_next.ledOk = stnPwrSync && contSync;
    st_next.ledPar = parSync;
    st_next.ledActive = expandedSync && st_next.chainEn;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign ioRdData = st_reg.rdData;
  assign ioRdValid = st_reg.rdValid;
  assign chainEnable = st_reg.chainEn;
  assign systemStop = st_reg.sysStop;
  assign ledChainOk = st_reg.ledOk;
  assign ledChainParity = st_reg.ledPar;
  assign ledIsoPower = st_reg.ledIso;
  assign ledFaultEnable = st_reg.ledFault;
  assign ledChainActive = st_reg.ledActive;

  property p_attach;
    @(posedge ref_clk) disable iff (rst)
      (ioWrStb && selHit(ioAddr) && isoOkSync && ioWrData == {5'h00, chanSync})
      |=> (st_reg.link == IOCT_ATTACHED);
  endproperty
  a_attach: assert property (p_attach) else $error("no attach on own channel");

  property p_detach;
    @(posedge ref_clk) disable iff (rst)
      (ioWrStb && selHit(ioAddr) && ioWrData != {5'h00, chanSync}
       && ioWrData != `IOCT_BCAST_CODE) |=> (st_reg.link == IOCT_DETACHED);
  endproperty
  a_detach: assert property (p_detach) else $error("no detach on other value");

  sequence s_bcast_wr;
    ioWrStb && selHit(ioAddr) && isoOkSync && ioWrData == `IOCT_BCAST_CODE;
  endsequence
  property p_bcast;
    @(posedge ref_clk) disable iff (rst)
      s_bcast_wr ##1 (ioRdStb && selHit(ioAddr)) |=> !ioRdValid;
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast answered a read");

  property p_status;
    @(posedge ref_clk) disable iff (rst)
      ioRdValid |-> (ioRdData[2:0] == $past(chanSync) && ioRdData[5:4] == 2'b00
                     && ioRdData[3]);
  endproperty
  a_status: assert property (p_status) else $error("status byte layout wrong");

  property p_normal;
    @(posedge ref_clk) disable iff (rst)
      (!expandedSync && isoOkSync) |=> chainEnable;
  endproperty
  a_normal: assert property (p_normal) else $error("normal mode chain off");

  property p_fault_led;
    @(posedge ref_clk) disable iff (rst)
      ##1 (ledFaultEnable == $past(faultStopSync));
  endproperty
  a_fault_led: assert property (p_fault_led) else $error("fault led mismatch");

  property p_shutdown;
    @(posedge ref_clk) disable iff (rst)
      !isoOkSync |=> (!chainEnable && !ledIsoPower) ##1 !ioRdValid;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("no shutdown on bad supply");

  property p_chain_ok;
    @(posedge ref_clk) disable iff (rst)
      ledChainOk |-> $past(stnPwrSync) && $past(contSync);
  endproperty
  a_chain_ok: assert property (p_chain_ok) else $error("chain ok led wrong");

  property p_parity;
    @(posedge ref_clk) disable iff (rst)
      ##1 (ledChainParity == $past(parSync));
  endproperty
  a_parity: assert property (p_parity) else $error("parity led wrong");

  property p_active;
    @(posedge ref_clk) disable iff (rst)
      ledChainActive |-> chainEnable;
  endproperty
  a_active: assert property (p_active) else $error("active led without chain");

  property p_stop_on;
    @(posedge ref_clk) disable iff (rst)
      (faultStopSync && faultSync) |=> systemStop;
  endproperty
  a_stop_on: assert property (p_stop_on) else $error("no stop on local fault");

  property p_stop_off;
    @(posedge ref_clk) disable iff (rst)
      !(faultStopSync && faultSync) |=> !systemStop;
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("stop without cause");

  property p_iso_on;
    @(posedge ref_clk) disable iff (rst)
      isoOkSync |=> ledIsoPower;
  endproperty
  a_iso_on: assert property (p_iso_on) else $error("power led off");

  property p_shut_link;
    @(posedge ref_clk) disable iff (rst)
      !isoOkSync |=> (st_reg.link == IOCT_DETACHED);
  endproperty
  a_shut_link: assert property (p_shut_link) else $error("link kept on bad supply");

  property p_rd_refused;
    @(posedge ref_clk) disable iff (rst)
      (ioRdStb && !isoOkSync) |=> !ioRdValid;
  endproperty
  a_rd_refused: assert property (p_rd_refused) else $error("answer on bad supply");

  property p_chain_ok_on;
    @(posedge ref_clk) disable iff (rst)
      (stnPwrSync && contSync) |=> ledChainOk;
  endproperty
  a_chain_ok_on: assert property (p_chain_ok_on) else $error("chain ok led off");

  property p_bcast_attach;
    @(posedge ref_clk) disable iff (rst)
      s_bcast_wr |=> chainEnable;
  endproperty
  a_bcast_attach: assert property (p_bcast_attach) else $error("no broadcast attach");

  property p_quiet;
    @(posedge ref_clk) disable iff (rst)
      !ioRdValid |-> (ioRdData == `IOCT_STATUS_RST);
  endproperty
  a_quiet: assert property (p_quiet) else $error("data without answer");

  property p_exp_detach;
    @(posedge ref_clk) disable iff (rst)
      (expandedSync && ioWrStb && selHit(ioAddr) && ioWrData != {5'h00, chanSync}
       && ioWrData != `IOCT_BCAST_CODE) |=> !chainEnable;
  endproperty
  a_exp_detach: assert property (p_exp_detach) else $error("chain kept on");

  // own number written, then a read with no gap: answer must follow
  sequence s_own_wr;
    ioWrStb && selHit(ioAddr) && isoOkSync && ioWrData == {5'h00, chanSync};
  endsequence
  sequence s_sel_rd;
    ioRdStb && selHit(ioAddr) && isoOkSync;
  endsequence
  property p_answer;
    @(posedge ref_clk) disable iff (rst)
      s_own_wr ##1 s_sel_rd |=> ioRdValid;
  endproperty
  a_answer: assert property (p_answer) else $error("own channel read unanswered");

  property p_status_hi;
    @(posedge ref_clk) disable iff (rst)
      ioRdValid |-> (ioRdData[`IOCT_ST_TRAP_BIT] == $past(faultStopSync)
                     && ioRdData[`IOCT_ST_FAULT_BIT] == $past(faultSync));
  endproperty
  a_status_hi: assert property (p_status_hi) else $error("status top bits wrong");

  property p_active_mode;
    @(posedge ref_clk) disable iff (rst)
      ledChainActive |-> $past(expandedSync);
  endproperty
  a_active_mode: assert property (p_active_mode) else $error("active led wrong");
endmodule

/* ioct_ctrl_model.sv */
/*
  controller side model: status byte store of the i/o scan.
  assumes read strobes and answers on ref_clk.
*/
module ioct_ctrl_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ioRdStb,
  input wire logic ioRdValid,
  input wire ioct_pkg::ioct_byte_t ioRdData
);
  timeunit 1ns;
  timeprecision 100ps;
  import ioct_pkg::*;
  // bit 0 is input 1017, bit 7 is input 1024
  // one channel byte only; chain and point counts stay in limits
  ioct_byte_t statusTable;
  int scanCount;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      statusTable <= 8'h00;
      scanCount <= 0;
    end else begin
      if (ioRdStb) scanCount <= scanCount + 1; // scanned answered or not
      // no answer leaves the table as it was
      if (ioRdValid) statusTable <= ioRdData;
    end
  end
endmodule

/* ioct_transmitter_tb.sv */
/*
  self-checking bench of the channel transmitter.
  assumes 3-edge pin latency and 1-cycle read answer.
*/
module ioct_transmitter_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [6:0] ioAddr = 7'h00;
  ioct_pkg::ioct_byte_t ioWrData = 8'h00;
  logic ioWrStb = 1'b0;
  logic ioRdStb = 1'b0;
  ioct_pkg::ioct_byte_t ioRdData;
  logic ioRdValid;
  ioct_pkg::ioct_chan_t chanSwitch = 3'h5; // not 0 or 8: needs its transmitter
  logic fault_stop_select_jumper = 1'b1;
  logic chain_mode_select_jumper = 1'b1; // lone module heads its link
  logic isoSupplyOk = 1'b1;
  logic stationPowerOk = 1'b1;
  logic cableContinuityOk = 1'b1;
  logic downstreamParityOk = 1'b1;
  logic localFault = 1'b0;
  logic chainEnable, systemStop, ledChainOk, ledChainParity;
  logic ledIsoPower, ledFaultEnable, ledChainActive;
  int num_errors = 0;
  int samples_checked = 0;

  always #5 ref_clk = ~ref_clk;

  ioct_transmitter ioct_transmitter_i (.ref_clk, .rst, .ioAddr, .ioWrData,
    .ioWrStb, .ioRdStb, .ioRdData, .ioRdValid, .chanSwitch,
    .fault_stop_select_jumper, .chain_mode_select_jumper, .isoSupplyOk,
    .stationPowerOk, .cableContinuityOk, .downstreamParityOk, .localFault,
    .chainEnable, .systemStop, .ledChainOk, .ledChainParity, .ledIsoPower,
    .ledFaultEnable, .ledChainActive);

  ioct_ctrl_model ioct_ctrl_model_i (.ref_clk, .rst, .ioRdStb, .ioRdValid,
    .ioRdData);

  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk1(string n, logic e, logic g);
    chk(n, {7'h00, e}, {7'h00, g});
  endtask

  task automatic wr(logic [6:0] a, logic [7:0] d);
    @(posedge ref_clk);
    ioAddr <= a;
    ioWrData <= d;
    ioWrStb <= 1'b1;
    @(posedge ref_clk);
    ioWrStb <= 1'b0;
    #1;
  endtask

  // answer stands one cycle only, so caller checks right away
  task automatic rd();
    @(posedge ref_clk);
    ioAddr <= 7'h7f;
    ioRdStb <= 1'b1;
    @(posedge ref_clk);
    ioRdStb <= 1'b0;
    #1;
  endtask

  // selector write then read with no gap, as a scan may issue them
  task automatic wr_rd(logic [7:0] d);
    @(posedge ref_clk);
    ioAddr <= 7'h7f;
    ioWrData <= d;
    ioWrStb <= 1'b1;
    @(posedge ref_clk);
    ioWrStb <= 1'b0;
    ioRdStb <= 1'b1;
    @(posedge ref_clk);
    ioRdStb <= 1'b0;
    #1;
  endtask

  // two sync flops plus output register
  task automatic settle();
    repeat (4) @(posedge ref_clk);
    #1;
  endtask

  task automatic t_attach();
    wr(7'h10, 8'h05);
    chk1("unmapped", 1'b0, chainEnable);
    wr(7'h7f, 8'h05);
    chk1("attach", 1'b1, chainEnable);
    chk1("active", 1'b1, ledChainActive);
    rd();
    chk1("valid", 1'b1, ioRdValid);
    chk("status", 8'h4d, ioRdData);
    $display("test attach done");
  endtask

  task automatic t_detach();
    wr(7'h7f, 8'h0d);
    chk1("detach13", 1'b0, chainEnable);
    chk("table", 8'h4d, ioct_ctrl_model_i.statusTable);
    wr(7'h7f, 8'h06);
    chk1("detach", 1'b0, chainEnable);
    chk1("inactive", 1'b0, ledChainActive);
    rd();
    chk1("novalid", 1'b0, ioRdValid);
    chk("nodata", 8'h00, ioRdData);
    chk("scans", 8'h02, 8'(ioct_ctrl_model_i.scanCount));
    $display("test detach done");
  endtask

  task automatic t_bcast();
    wr(7'h7f, 8'h80);
    chk1("bcast", 1'b1, chainEnable);
    chk("keep", 8'h4d, ioct_ctrl_model_i.statusTable);
    rd();
    chk1("bcastrd", 1'b0, ioRdValid);
    wr_rd(8'h80);
    chk1("bcastb2b", 1'b0, ioRdValid);
    $display("test broadcast done");
  endtask

  task automatic t_fault();
    localFault <= 1'b1;
    settle();
    chk1("stop", 1'b1, systemStop);
    chk1("fen", 1'b1, ledFaultEnable);
    wr_rd(8'h05);
    chk1("b2bvalid", 1'b1, ioRdValid);
    chk("stfault", 8'hcd, ioRdData);
    fault_stop_select_jumper <= 1'b0;
    settle();
    chk1("nostop", 1'b0, systemStop);
    chk1("nofen", 1'b0, ledFaultEnable);
    rd();
    chk("stnotrap", 8'h8d, ioRdData);
    localFault <= 1'b0;
    $display("test fault done");
  endtask

  task automatic t_leds();
    stationPowerOk <= 1'b0;
    settle();
    chk1("chok_pw", 1'b0, ledChainOk);
    stationPowerOk <= 1'b1;
    cableContinuityOk <= 1'b0;
    downstreamParityOk <= 1'b0;
    settle();
    chk1("chok_cc", 1'b0, ledChainOk);
    chk1("par", 1'b0, ledChainParity);
    cableContinuityOk <= 1'b1;
    downstreamParityOk <= 1'b1;
    settle();
    chk1("chok", 1'b1, ledChainOk);
    chk1("parok", 1'b1, ledChainParity);
    $display("test leds done");
  endtask

  task automatic t_mode();
    chain_mode_select_jumper <= 1'b0;
    settle();
    wr(7'h7f, 8'h06);
    chk1("normal", 1'b1, chainEnable);
    chk1("nactive", 1'b0, ledChainActive);
    chain_mode_select_jumper <= 1'b1;
    settle();
    $display("test mode done");
  endtask

  task automatic t_supply();
    isoSupplyOk <= 1'b0;
    settle();
    chk1("shut", 1'b0, chainEnable);
    chk1("isoled", 1'b0, ledIsoPower);
    wr(7'h7f, 8'h05);
    chk1("shutwr", 1'b0, chainEnable);
    isoSupplyOk <= 1'b1;
    settle();
    chk1("isoledok", 1'b1, ledIsoPower);
    $display("test supply done");
  endtask

  // mid-run reset must drop the link and blank the outputs
  task automatic t_reset();
    wr(7'h7f, 8'h05);
    chk1("preattach", 1'b1, chainEnable);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk1("rstchain", 1'b0, chainEnable);
    chk1("rstiso", 1'b0, ledIsoPower);
    settle();
    chk1("rstlink", 1'b0, chainEnable);
    chk1("rstisook", 1'b1, ledIsoPower);
    $display("test reset done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // whole run needs well under 500 cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    num_errors++;
    $display("[FAIL] watchdog expected done seen hang");
    tally_and_finish();
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    settle();
    t_attach();
    t_detach();
    t_bcast();
    t_fault();
    t_leds();
    t_mode();
    t_supply();
    t_reset();
    tally_and_finish();
  end
endmodule
